// ### core/i2ct_map.svh
// Purpose: addresses, field positions and codes of the i2c tx block
// Assumes: byte addresses on an 8-bit apb address
// Notes: definitions only
`ifndef I2CT_MAP_SVH
`define I2CT_MAP_SVH
// ==========================================
// register byte addresses
`define I2CT_A_CTRL 8'h00
`define I2CT_A_TXD 8'h10
`define I2CT_A_STAT 8'h14
`define I2CT_A_RAW 8'h20
`define I2CT_A_MASK 8'h24
// ==========================================
// control register fields
`define I2CT_C_DMA 0
`define I2CT_C_GO 1
`define I2CT_C_ADR 14:8
`define I2CT_C_THR 19:16
`define I2CT_C_BST 22:20
// ==========================================
// interrupt bit positions
`define I2CT_I_SLAVE_READ_REQUEST_FLAG 0
`define I2CT_I_SLAVE_READ_EMPTY_FLAG 1
`define I2CT_I_STD 2
`define I2CT_I_TX_NEARLY_EMPTY_FLAG 3
// ==========================================
// status codes
`define I2CT_OP_MW 2'h0
`define I2CT_OP_MR 2'h1
`define I2CT_OP_WTS 2'h2
`define I2CT_OP_RFS 2'h3
`define I2CT_PR_IDLE 2'h0
`define I2CT_PR_RUN 2'h1
`define I2CT_PR_OK 2'h2
`define I2CT_PR_ABT 2'h3
`define I2CT_CA_NADDR 3'h0
`define I2CT_CA_NDATA 3'h1
`define I2CT_CA_ARB 3'h3
`define I2CT_CA_START 3'h4
`define I2CT_CA_STOP 3'h5
`define I2CT_CA_FRAME_OVERLENGTH_REASON 3'h6
// ==========================================
// counts and sizes
`define I2CT_FAW 4
`define I2CT_DEPTH 5'h10
`define I2CT_NBITS 4'h8
`define I2CT_LAST 4'h7
`define I2CT_WTS_MAX 11'h7ff
`endif

// ### core/i2ct_pkg.sv
// Purpose: shared types of the i2c tx block
// Assumes: constants live in i2ct_map.svh
// Notes: state codes are gray along the usual path
package i2ct_pkg;
    // ==========================================
    // slave engine states
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_addr = 3'h1,
        st_aack = 3'h3,
        st_txld = 3'h2,
        st_txbit = 3'h6,
        st_txack = 3'h7,
        st_rxbit = 3'h5,
        st_rxack = 3'h4
    } i2ct_state_t;
    // status word, low seven bits of the status register
    typedef struct packed {
        logic [2:0] cause;
        logic [1:0] prog;
        logic [1:0] op;
    } i2ct_status_t;
    // dma request lines
    typedef struct packed {
        logic last;
        logic burst;
        logic single;
    } i2ct_dma_t;
    // two-stage synchroniser
    typedef struct packed {
        logic s2;
        logic s1;
    } i2ct_sync_t;
    // whole state of the top module
    typedef struct packed {
        i2ct_state_t state;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [10:0] bytes;
        logic sda_oe;
        logic scl_oe;
        logic scl_d;
        logic sda_d;
        i2ct_status_t stat;
        logic [3:0] raw;
        logic [3:0] mask;
        logic dma_en;
        logic [6:0] own;
        logic [3:0] thr;
        logic [2:0] burst;
        logic mw_pend;
        logic launch;
        logic [3:0] rd_ptr;
        logic [3:0] wr_ptr;
        logic [4:0] fcnt;
        logic slave_read_empty_flag_done;
        i2ct_dma_t dma;
        logic dma_fin;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic irq;
    } i2ct_top_t;
endpackage : i2ct_pkg

// ### core/i2ct_sync.sv
// Purpose: two flip-flop synchroniser for one pin
// Assumes: idle level of the pin is low at reset
// Notes: only the second stage is visible outside
`timescale 1ns/100ps
module i2ct_sync (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and result
    input wire logic din,
    output logic dout
);
    i2ct_pkg::i2ct_sync_t q;
    i2ct_pkg::i2ct_sync_t d;

    // ==========================================
    // next state
    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule : i2ct_sync

// ### core/i2ct_txmem.sv
// Purpose: storage of the transmit fifo
// Assumes: one write and one read address per cycle
// Notes: read data is registered, a same-cycle write is bypassed
`timescale 1ns/100ps
`include "i2ct_map.svh"
module i2ct_txmem (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write side
    input wire logic we,
    input wire logic [`I2CT_FAW-1:0] waddr,
    input wire logic [7:0] wdata,
    // read side
    input wire logic [`I2CT_FAW-1:0] raddr,
    output logic [7:0] rdata_q
);
    logic [7:0] mem_q [0:(1<<`I2CT_FAW)-1];

    // ==========================================
    // array write, no reset on the storage itself
    always_ff @(posedge pclk) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    // read register; bypass keeps a fresh byte from reading stale
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= '0;
        end else if (we && waddr == raddr) begin
            rdata_q <= wdata;
        end else begin
            rdata_q <= mem_q[raddr];
        end
    end
endmodule : i2ct_txmem

// ### core/i2ct_top.sv
// Purpose: i2c transmit fifo, slave transmitter and status reporting
// Assumes: scl and sda are asynchronous; master sequencer on pclk
// Notes: open-drain pins, oe high pulls the line low
`timescale 1ns/100ps
`include "i2ct_map.svh"
// Notes on behaviour
// - master write waits for fifo data
// - addressed for read raises read request
// - empty fifo mid-read raises refill request
// - empty slave transmitter holds scl low
// - fifo flushed before read request
// - read end sets done flag, status
// - nearly-empty flag paces cpu refills
// - dma single or burst by free space
// - dummy last dma request after nack
// - status bits 1:0 give operation
// - status bits 3:2 give progress
// - status bits 6:4 give abort cause
// - master nack and arbitration cause codes
// - early start or stop cause codes
// - write over 2047 bytes gets nack
module i2ct_top (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // i2c pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // master sequencer
    input wire logic mst_pop,
    input wire logic mst_done,
    input wire logic mst_abort,
    input wire logic [2:0] mst_cause,
    output logic mst_launch,
    output logic [7:0] mst_byte,
    // dma and interrupt
    input wire logic dma_ack,
    output i2ct_pkg::i2ct_dma_t dma_req,
    output logic irq
);
    i2ct_pkg::i2ct_top_t q;
    i2ct_pkg::i2ct_top_t d;
    logic scl_s;
    logic sda_s;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic mid;
    logic acc;
    logic push;
    logic push_ok;
    logic pop;
    logic flush;
    logic fin;
    logic [1:0] fin_pr;
    logic [2:0] fin_ca;
    logic [3:0] ev;
    logic [3:0] clr;
    logic [4:0] free;
    logic rfs_run;
    logic [7:0] rdata;

    // ==========================================
    // pin synchronisers
    i2ct_sync u_scl (
        .pclk(pclk),
        .presetn(presetn),
        .din(scl_i),
        .dout(scl_s)
    );
    i2ct_sync u_sda (
        .pclk(pclk),
        .presetn(presetn),
        .din(sda_i),
        .dout(sda_s)
    );

    // fifo storage, read address follows the next read pointer
    i2ct_txmem u_mem (
        .pclk(pclk),
        .presetn(presetn),
        .we(push_ok),
        .waddr(q.wr_ptr),
        .wdata(pwdata[7:0]),
        .raddr(d.rd_ptr),
        .rdata_q(rdata)
    );

    // ==========================================
    // next state
    always_comb begin
        d = q;
        d.launch = 1'b0;
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        d.prdata = '0;
        d.scl_d = scl_s;
        d.sda_d = sda_s;
        push = 1'b0;
        pop = 1'b0;
        flush = 1'b0;
        fin = 1'b0;
        fin_pr = `I2CT_PR_OK;
        fin_ca = q.stat.cause;
        ev = '0;
        clr = '0;
        // bus events on the synchronised lines
        rise = scl_s & ~q.scl_d;
        fall = ~scl_s & q.scl_d;
        start = scl_s & q.scl_d & q.sda_d & ~sda_s;
        stop = scl_s & q.scl_d & ~q.sda_d & sda_s;
        // one rise at a byte boundary is the stop or start clock itself
        mid = (q.state == i2ct_pkg::st_txbit)
            || ((q.state == i2ct_pkg::st_addr
                 || q.state == i2ct_pkg::st_rxbit) && q.cnt > 4'h1);
        rfs_run = q.stat.op == `I2CT_OP_RFS
            && q.stat.prog == `I2CT_PR_RUN;
        free = `I2CT_DEPTH - q.fcnt;
        acc = psel & penable & ~q.pready;

        // apb access phase, answered one cycle in
        if (acc) begin
            d.pready = 1'b1;
            case (paddr)
                `I2CT_A_CTRL: begin
                    if (pwrite) begin
                        d.dma_en = pwdata[`I2CT_C_DMA];
                        d.mw_pend = q.mw_pend | pwdata[`I2CT_C_GO];
                        d.own = pwdata[`I2CT_C_ADR];
                        d.thr = pwdata[`I2CT_C_THR];
                        d.burst = pwdata[`I2CT_C_BST];
                    end
                    d.prdata[`I2CT_C_DMA] = q.dma_en;
                    d.prdata[`I2CT_C_GO] = q.mw_pend;
                    d.prdata[`I2CT_C_ADR] = q.own;
                    d.prdata[`I2CT_C_THR] = q.thr;
                    d.prdata[`I2CT_C_BST] = q.burst;
                end
                `I2CT_A_TXD: begin
                    push = pwrite; // write-only port, reads zero
                end
                `I2CT_A_STAT: begin
                    d.prdata[6:0] = q.stat; // upper bits zero
                end
                `I2CT_A_RAW: begin
                    if (pwrite) begin
                        clr = pwdata[3:0];
                    end
                    d.prdata[3:0] = q.raw;
                end
                `I2CT_A_MASK: begin
                    if (pwrite) begin
                        d.mask = pwdata[3:0];
                    end
                    d.prdata[3:0] = q.mask;
                end
                default: begin
                    d.pslverr = 1'b1;
                end
            endcase
        end

        // master write launch only once bytes wait
        if (q.mw_pend && q.fcnt != '0 && q.state == i2ct_pkg::st_idle
            && q.stat.prog != `I2CT_PR_RUN) begin
            d.mw_pend = 1'b0;
            d.launch = 1'b1;
            d.stat = {`I2CT_CA_NADDR, `I2CT_PR_RUN, `I2CT_OP_MW};
        end
        // sequencer reports its end and abort cause
        if (q.stat.op == `I2CT_OP_MW && q.stat.prog == `I2CT_PR_RUN) begin
            pop = mst_pop;
            if (mst_abort) begin
                d.stat.prog = `I2CT_PR_ABT;
                d.stat.cause = mst_cause;
            end else if (mst_done) begin
                d.stat.prog = `I2CT_PR_OK;
            end
        end

        // slave engine; start and stop override any state
        if (start) begin
            if (mid) begin
                fin = 1'b1;
                fin_pr = `I2CT_PR_ABT;
                fin_ca = `I2CT_CA_START;
            end
            d.state = i2ct_pkg::st_addr;
            d.cnt = '0;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else if (stop && q.state != i2ct_pkg::st_idle) begin
            fin = 1'b1;
            if (mid) begin
                fin_pr = `I2CT_PR_ABT;
                fin_ca = `I2CT_CA_STOP;
            end
            d.state = i2ct_pkg::st_idle;
            d.sda_oe = 1'b0;
            d.scl_oe = 1'b0;
        end else begin
            unique case (q.state)
                i2ct_pkg::st_idle: begin
                end
                i2ct_pkg::st_addr: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], sda_s};
                        d.cnt = q.cnt + 4'h1;
                    end
                    if (fall && q.cnt == `I2CT_NBITS) begin
                        d.state = i2ct_pkg::st_idle;
                        if (q.sh[7:1] == q.own && !(q.stat.prog
                            == `I2CT_PR_RUN && !q.stat.op[1])) begin
                            d.state = i2ct_pkg::st_aack;
                            d.rw = q.sh[0];
                            d.sda_oe = 1'b1;
                            d.bytes = '0;
                            d.slave_read_empty_flag_done = 1'b1;
                            d.stat = {`I2CT_CA_NADDR, `I2CT_PR_RUN,
                                      q.sh[0] ? `I2CT_OP_RFS
                                              : `I2CT_OP_WTS};
                            if (q.sh[0]) begin
                                flush = 1'b1;
                                ev[`I2CT_I_SLAVE_READ_REQUEST_FLAG] = 1'b1;
                            end
                        end
                    end
                end
                i2ct_pkg::st_aack: begin
                    if (fall) begin
                        d.sda_oe = 1'b0;
                        d.cnt = '0;
                        d.state = q.rw ? i2ct_pkg::st_txld
                                       : i2ct_pkg::st_rxbit;
                    end
                end
                i2ct_pkg::st_txld: begin
                    // scl is low here; keep it low until a byte is in
                    if (q.fcnt == '0) begin
                        d.scl_oe = 1'b1;
                        if (!q.slave_read_empty_flag_done) begin
                            ev[`I2CT_I_SLAVE_READ_EMPTY_FLAG] = 1'b1;
                            d.slave_read_empty_flag_done = 1'b1;
                        end
                    end else begin
                        pop = 1'b1;
                        d.sh = rdata;
                        d.sda_oe = ~rdata[0]; // bit 0 goes out first
                        d.slave_read_empty_flag_done = 1'b0;
                        d.cnt = '0;
                        d.state = i2ct_pkg::st_txbit;
                    end
                end
                i2ct_pkg::st_txbit: begin
                    // scl let go a cycle after sda is set up
                    d.scl_oe = 1'b0;
                    if (fall) begin
                        d.cnt = q.cnt + 4'h1;
                        if (q.cnt == `I2CT_LAST) begin
                            d.sda_oe = 1'b0;
                            d.state = i2ct_pkg::st_txack;
                        end else begin
                            d.sh = {1'b0, q.sh[7:1]};
                            d.sda_oe = ~q.sh[1];
                        end
                    end
                end
                i2ct_pkg::st_txack: begin
                    if (rise) begin
                        d.nack = sda_s;
                    end
                    if (fall) begin
                        if (q.nack) begin
                            fin = 1'b1;
                            d.dma_fin = q.dma_en;
                            d.state = i2ct_pkg::st_idle;
                        end else begin
                            d.state = i2ct_pkg::st_txld;
                        end
                    end
                end
                i2ct_pkg::st_rxbit: begin
                    if (rise) begin
                        d.cnt = q.cnt + 4'h1;
                    end
                    if (fall && q.cnt == `I2CT_NBITS) begin
                        d.cnt = '0;
                        if (q.bytes == `I2CT_WTS_MAX) begin
                            // no ack: the master sees a nack
                            fin = 1'b1;
                            fin_pr = `I2CT_PR_ABT;
                            fin_ca = `I2CT_CA_FRAME_OVERLENGTH_REASON;
                            d.state = i2ct_pkg::st_idle;
                        end else begin
                            d.bytes = q.bytes + 11'h1;
                            d.sda_oe = 1'b1;
                            d.state = i2ct_pkg::st_rxack;
                        end
                    end
                end
                i2ct_pkg::st_rxack: begin
                    if (fall) begin
                        d.sda_oe = 1'b0;
                        d.state = i2ct_pkg::st_rxbit;
                    end
                end
            endcase
        end

        // end of a slave operation; cause kept only on abort
        if (fin && q.stat.op[1] && q.stat.prog == `I2CT_PR_RUN) begin
            d.stat.prog = fin_pr;
            d.stat.cause = fin_pr == `I2CT_PR_ABT ? fin_ca
                                                  : q.stat.cause;
            if (q.stat.op == `I2CT_OP_RFS) begin
                ev[`I2CT_I_STD] = 1'b1;
            end
        end

        // fifo pointers; flush discards a push in the same cycle
        push_ok = push & (q.fcnt != `I2CT_DEPTH) & ~flush;
        pop = pop & (q.fcnt != '0) & ~flush;
        if (flush) begin
            d.rd_ptr = q.wr_ptr;
            d.fcnt = '0;
        end else begin
            d.wr_ptr = q.wr_ptr + {3'h0, push_ok};
            d.rd_ptr = q.rd_ptr + {3'h0, pop};
            d.fcnt = q.fcnt + {4'h0, push_ok} - {4'h0, pop};
        end
        // nearly-empty on crossing the threshold
        if (d.fcnt <= {1'b0, q.thr} && q.fcnt > {1'b0, q.thr}) begin
            ev[`I2CT_I_TX_NEARLY_EMPTY_FLAG] = 1'b1;
        end

        // dma requests, held until acknowledged
        if (dma_ack) begin
            d.dma = '0;
        end else if (q.dma == '0 && q.dma_en
                     && (q.dma_fin || (rfs_run && free != '0))) begin
            d.dma.last = q.dma_fin; // dummy final request
            d.dma_fin = 1'b0;
            if (q.burst != '0 && free >= {2'h0, q.burst}) begin
                d.dma.burst = 1'b1;
            end else begin
                d.dma.single = 1'b1;
            end
        end

        // sticky flags, a new event wins over its clear
        d.raw = (q.raw & ~clr) | ev;
        d.irq = |(d.raw & d.mask);
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // outputs from flops; scl_o and sda_o tied low
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe = q.scl_oe;
    assign sda_oe = q.sda_oe;
    assign mst_launch = q.launch;
    assign mst_byte = rdata;
    assign dma_req = q.dma;
    assign irq = q.irq;

    // ==========================================
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_rd_match;
        q.state == i2ct_pkg::st_addr ##0 d.state == i2ct_pkg::st_aack
            ##0 d.rw;
    endsequence
    sequence s_flushed;
        q.fcnt == '0 ##0 q.raw[`I2CT_I_SLAVE_READ_REQUEST_FLAG]
            ##0 q.stat.op == `I2CT_OP_RFS;
    endsequence
    rd_flush_a: assert property (s_rd_match |=> s_flushed)
        else $error("read match without flush and request");
    stretch_hold_a: assert property (
        (q.state == i2ct_pkg::st_txld && q.fcnt == '0 && !start
         && !stop) |=> q.scl_oe)
        else $error("scl not held with empty fifo");
    refill_req_a: assert property (
        (q.state == i2ct_pkg::st_txld && q.fcnt == '0 && !q.slave_read_empty_flag_done
         && !start && !stop) |=> q.raw[`I2CT_I_SLAVE_READ_EMPTY_FLAG])
        else $error("refill request missing");
    read_done_a: assert property (
        (q.state == i2ct_pkg::st_txack && fall && q.nack && rfs_run
         && !start && !stop) |=> (q.raw[`I2CT_I_STD]
         && q.stat.prog == `I2CT_PR_OK && q.stat.op == `I2CT_OP_RFS))
        else $error("read end not reported");
    mw_hold_a: assert property (
        (q.mw_pend && q.fcnt == '0) |=> !q.launch)
        else $error("master write launched on empty fifo");
    frame_overlength_reason_nack_a: assert property (
        (q.state == i2ct_pkg::st_rxbit && fall && !start && !stop
         && q.cnt == `I2CT_NBITS && q.bytes == `I2CT_WTS_MAX && rfs_run
         == 1'b0 && q.stat.prog == `I2CT_PR_RUN)
        |=> (!q.sda_oe [*2] ##0 q.stat.cause == `I2CT_CA_FRAME_OVERLENGTH_REASON))
        else $error("overlong write not refused");
    dma_last_a: assert property (
        (q.dma_fin && q.dma == '0 && q.dma_en && !dma_ack)
        |=> (q.dma.last && (q.dma.single || q.dma.burst)))
        else $error("dummy last request missing");
    burst_pick_a: assert property (
        (q.dma == '0 && q.dma_en && rfs_run && !q.dma_fin && !dma_ack
         && q.burst != '0 && free >= {2'h0, q.burst})
        |=> (q.dma.burst && !q.dma.single))
        else $error("burst not chosen with room");
    stat_read_a: assert property (
        (acc && !pwrite && paddr == `I2CT_A_STAT)
        |=> (q.pready && q.prdata == {25'h0, $past(q.stat)}))
        else $error("status read value wrong");
endmodule : i2ct_top

// ### verification/i2ct_master_model.sv
// Purpose: behavioural i2c master on the open-drain wire
// Assumes: pull-ups on both lines, bit time 32 ns
// Notes: bounded wait while the slave stretches scl
`timescale 1ns/100ps
module i2ct_master_model (
    // wire levels
    input wire logic scl_line,
    input wire logic sda_line,
    // pull-downs of this master
    output logic scl_pull,
    output logic sda_pull
);
    // ==========================================
    // bit and frame tasks
    initial begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end
    // high phase starts only once the slave lets scl go
    task automatic clk_bit(input logic v, output logic s);
        int n;
        n = 0;
        sda_pull = ~v;
        #8;
        scl_pull = 1'b0;
        while (scl_line !== 1'b1 && n < 5000) begin
            #4;
            n++;
        end
        #8;
        s = sda_line;
        #8;
        scl_pull = 1'b1;
        #8;
    endtask : clk_bit
    // start, address msb first, then the ack slot
    task automatic frame_open(input logic [7:0] a, output logic k);
        logic s;
        sda_pull = 1'b1;
        #16;
        scl_pull = 1'b1;
        #8;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(a[i], s);
        end
        clk_bit(1'b1, k);
    endtask : frame_open
    // one byte from the slave, then ack (0) or nack (1)
    task automatic get(input logic nk, output logic [7:0] b);
        logic s;
        for (int i = 0; i < 8; i++) begin
            clk_bit(1'b1, s);
            b[i] = s;
        end
        clk_bit(nk, s);
    endtask : get
    task automatic stop();
        sda_pull = 1'b1;
        #8;
        scl_pull = 1'b0;
        #16;
        sda_pull = 1'b0;
        #16;
    endtask : stop
endmodule : i2ct_master_model

// ### verification/i2c_tx_fifo_and_status_bench.sv
// Purpose: apb reads and two slave read frames on the wire
// Assumes: sequencer inputs idle, so a master write is launched but never ends
// Notes: wt samples 1 ns after edges so register updates have landed; apb and the launch check read at the edge
`timescale 1ns/100ps
`include "i2ct_map.svh"
module i2c_tx_fifo_and_status_bench;
    // ==========================================
    // signals
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] x;
        logic e;
    } i2ct_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, dma_ack = 1'b0, pready, pslverr, scl_o, scl_oe;
    logic sda_o, sda_oe, mst_launch, irq, scl_pull, sda_pull, k, e;
    logic [7:0] paddr = 8'h00, mst_byte, b;
    logic [31:0] pwdata = 32'h0, prdata, r;
    i2ct_pkg::i2ct_dma_t dma_req;
    int err_count = 0, tests_run = 0, cyc = 0;
    wire scl_line = ~(scl_oe | scl_pull);
    wire sda_line = ~(sda_oe | sda_pull);
    i2ct_row_t rows [6] = '{'{`I2CT_A_STAT, 32'h0, 1'b0},
        '{`I2CT_A_TXD, 32'h0, 1'b0}, '{`I2CT_A_RAW, 32'h0, 1'b0},
        '{`I2CT_A_MASK, 32'h0, 1'b0}, '{8'h30, 32'h0, 1'b1},
        '{8'h15, 32'h0, 1'b1}};
    initial forever #2 pclk = ~pclk;
    i2ct_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .scl_i(scl_line), .scl_o,
        .scl_oe, .sda_i(sda_line), .sda_o, .sda_oe, .mst_pop(1'b0),
        .mst_done(1'b0), .mst_abort(1'b0), .mst_cause(3'h0),
        .mst_launch, .mst_byte, .dma_ack, .dma_req, .irq);
    i2ct_master_model mdl (.scl_line, .sda_line, .scl_pull, .sda_pull);
    // ==========================================
    // tasks
    task automatic chk(input string n, input logic [31:0] x,
        input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // setup, access until pready, release on the sampling edge
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) begin
            err_count++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    task automatic dack();
        @(posedge pclk);
        dma_ack <= 1'b1;
        @(posedge pclk);
        dma_ack <= 1'b0;
    endtask : dack
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    // hang guard, far above the several hundred cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_count++;
            end_of_test();
        end
    end
    // ==========================================
    // sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk("rdata", rows[i].x, r);
            chk("slverr", {31'h0, rows[i].e}, {31'h0, e});
        end
        apb(1'b1, `I2CT_A_MASK, 32'h5);
        apb(1'b1, `I2CT_A_CTRL, 32'h2a00);
        apb(1'b1, `I2CT_A_TXD, 32'ha5); // stale byte, must be flushed
        mdl.frame_open(8'h55, k);
        wt(8);
        chk("ack", {31'h0, k}, 32'h0);
        chk("stretch", {31'h0, scl_oe}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        apb(1'b0, `I2CT_A_RAW, 32'h0);
        chk("raw", r & 32'hf, 32'h9);
        apb(1'b0, `I2CT_A_STAT, 32'h0);
        chk("stat", r, 32'h7);
        apb(1'b1, `I2CT_A_RAW, 32'hf);
        apb(1'b1, `I2CT_A_TXD, 32'h1c3);
        mdl.get(1'b1, b);
        mdl.stop();
        chk("byte", {24'h0, b}, 32'hc3);
        apb(1'b0, `I2CT_A_RAW, 32'h0);
        chk("raw", r & 32'h7, 32'h4);
        apb(1'b0, `I2CT_A_STAT, 32'h0);
        chk("stat", r, 32'hb);
        apb(1'b1, `I2CT_A_CTRL, 32'h2a01);
        mdl.frame_open(8'h55, k);
        wt(8);
        chk("dma", {29'h0, dma_req}, 32'h1);
        dack();
        apb(1'b1, `I2CT_A_TXD, 32'h3c);
        mdl.get(1'b0, b);
        chk("byte", {24'h0, b}, 32'h3c);
        wt(8);
        chk("stretch", {31'h0, scl_oe}, 32'h1);
        apb(1'b0, `I2CT_A_RAW, 32'h0);
        chk("refill", r & 32'h2, 32'h2);
        apb(1'b1, `I2CT_A_TXD, 32'h5a);
        mdl.get(1'b1, b);
        mdl.stop();
        chk("byte", {24'h0, b}, 32'h5a);
        wt(8);
        dack();
        wt(4);
        chk("last", {31'h0, dma_req.last}, 32'h1);
        mdl.frame_open(8'h54, k);
        mdl.stop();
        chk("ack", {31'h0, k}, 32'h0);
        apb(1'b0, `I2CT_A_STAT, 32'h0);
        chk("stat", r, 32'ha);
        apb(1'b1, `I2CT_A_CTRL, 32'h2a02);
        wt(8);
        apb(1'b0, `I2CT_A_CTRL, 32'h0);
        chk("pending", r & 32'h2, 32'h2);
        apb(1'b1, `I2CT_A_TXD, 32'h77);
        @(posedge pclk);
        chk("launch", {31'h0, mst_launch}, 32'h1);
        chk("head", {24'h0, mst_byte}, 32'h77);
        apb(1'b0, `I2CT_A_STAT, 32'h0);
        chk("stat", r, 32'h4);
        end_of_test();
    end
endmodule : i2c_tx_fifo_and_status_bench
